// ===== modbus_srv_regs.svh
// named constants of the multiple-write request handler
// assumes: included by bare name from the package and the design files
`ifndef MODBUS_SRV_REGS_SVH
`define MODBUS_SRV_REGS_SVH

// function codes
`define FC_COILS 8'h0F
`define FC_REGS 8'h10
`define FC_FILE_RD 8'h14
`define FC_PROG 8'h28
`define BCAST_ADDR 8'h00

// exception codes
`define EXC_FLAG 8'h80
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define EXC_FAIL 8'h04
`define EXC_ACK 8'h05
`define EXC_BUSY 8'h06
`define EXC_PARITY 8'h08
`define EXC_GW_PATH 8'h0A
`define EXC_GW_TGT 8'h0B

// request byte positions
`define IX_FUNC 9'h001
`define IX_SH 9'h002
`define IX_SL 9'h003
`define IX_QH 9'h004
`define IX_QL 9'h005
`define IX_BC 9'h006
`define HDR_LEN 9'h007
`define IDX_MAX 9'h107

// limits and sizes
`define MAX_REGS 16'h007D
`define COIL_RANGE 17'h00100
`define REG_RANGE 17'h00080
`define COIL_N 256
`define REG_N 128
`define COIL_AW 8
`define REG_AW 7
`define BUF_N 256
`define NORM_LAST 3'h5
`define EXC_LAST 3'h2

`endif

// ===== modbus_srv_pkg.sv
// types of the multiple-write request handler
// assumes: constants header compiled alongside
`include "modbus_srv_regs.svh"

package modbus_srv_pkg;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RECV = 5'h02,
        S_CHECK = 5'h04,
        S_WRITE = 5'h08,
        S_REPLY = 5'h10
    } fsm_t;

    typedef struct packed {
        fsm_t fsm;
        logic [7:0] addr;
        logic [7:0] func;
        logic [15:0] start;
        logic [15:0] qty;
        logic [7:0] bcnt;
        logic [8:0] idx;
        logic ovf;
        logic [15:0] k;
        logic fault;
        logic exc;
        logic [7:0] code;
        logic [2:0] ridx;
        logic [7:0] tx_data;
        logic prog;
    } srv_state_t;

endpackage

// ===== coil_bank.sv
// coil storage, one write port, all coils visible
// assumes: single clock; storage is never cleared by reset
`timescale 1ns/1ps
`include "modbus_srv_regs.svh"

module coil_bank (
    // clock
    input wire logic clock,
    // write port
    input wire logic we,
    input wire logic [`COIL_AW-1:0] waddr,
    input wire logic wdata,
    // coil state
    output logic [`COIL_N-1:0] coil_out
);
    import modbus_srv_pkg::*;

    // ******************************
    // per coil storage, no reset
    // ******************************
    genvar i;
    generate
        for (i = 0; i < `COIL_N; i++)
        begin : g_coil
            always_ff @(posedge clock)
            begin
                if (we && waddr == i[`COIL_AW-1:0])
                    coil_out[i] <= wdata;
            end
        end
    endgenerate

endmodule // coil_bank

// ===== holding_bank.sv
// holding register storage with one write and one read port
// assumes: single clock; contents are not cleared by reset
`timescale 1ns/1ps
`include "modbus_srv_regs.svh"

module holding_bank (
    // clock
    input wire logic clock,
    // write port
    input wire logic we,
    input wire logic [`REG_AW-1:0] waddr,
    input wire logic [15:0] wdata,
    // read port
    input wire logic [`REG_AW-1:0] raddr,
    output logic [15:0] rdata
);
    import modbus_srv_pkg::*;

    logic [15:0] mem [0:`REG_N-1];

    // ******************************
    // storage
    // ******************************
    always_ff @(posedge clock)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end

endmodule // holding_bank

// ===== modbus_write_server.sv
// request handler for multiple-coil and multiple-register writes
// assumes: framer strips the check field and flags bad frames on the last
// byte; all streams are on the same clock
// Function
// - unimplemented function or unconfigured server answers exception 01
// - start plus quantity beyond implemented range answers exception 02
// - structural fault in request body answers 03, never stored values
// - unrecoverable internal fault during a request answers 04
// - accepted long programming request answers 05; master polls later
// - while busy programming, new requests answer 06; master retries
// - record file read with memory parity fault answers 08
// - gateway unable to allocate a path answers 0a
// - gateway target giving no response answers 0b
// - function 0F sets each coil from one packed bit, one is on
// - coil addresses on the link start at zero
// - coil write to address zero is broadcast and is applied
// - broadcast valid only for write functions 0F and 10
// - coil write reply echoes address, function, start and quantity
// - coil writes happen whether or not coils are disabled
// - coils are not cleared at power-up
// - register write quantity above 125 is rejected
// - function 10 layout: header, byte count, high then low bytes
// - register write reply echoes address, function, start and quantity
// - exception reply carries function with msb set, then code byte
// - frame with framing, parity or check error gets no reply
`timescale 1ns/1ps
`include "modbus_srv_regs.svh"

module modbus_write_server (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // station setup and status
    input wire logic [7:0] my_addr,
    input wire logic configured,
    input wire logic prog_busy,
    input wire logic int_fault,
    input wire logic file_parity_err,
    input wire logic gw_path_fail,
    input wire logic gw_no_resp,
    output logic prog_start,
    // request stream
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_err,
    output logic rx_ready,
    // reply stream
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // coil and register view
    output logic [`COIL_N-1:0] coil_out,
    input wire logic [`REG_AW-1:0] hr_rd_addr,
    output logic [15:0] hr_rd_data
);
    import modbus_srv_pkg::*;

    srv_state_t s_q;
    srv_state_t s_d;
    logic [7:0] buf_mem [0:`BUF_N-1];
    logic acc;
    logic bcast;
    logic own;
    logic gw;
    logic len_ok;
    logic [16:0] coil_bytes;
    logic coil_struct;
    logic coil_range;
    logic reg_struct;
    logic reg_range;
    logic bcast_ok;
    logic [7:0] chk;
    logic [15:0] waddr16;
    logic [7:0] coil_byte;
    logic coil_we;
    logic [`COIL_AW-1:0] coil_waddr;
    logic coil_wdata;
    logic reg_we;
    logic [`REG_AW-1:0] reg_waddr;
    logic [15:0] reg_wdata;
    logic [7:0] buf_waddr;

    // ******************************
    // reply byte selection
    // ******************************
    function automatic logic [7:0] reply_byte(input srv_state_t s,
                                              input logic [2:0] i);
        logic [7:0] b;
        b = s.addr;
        case (i)
            3'h1: b = s.exc ? (s.func | `EXC_FLAG) : s.func;
            3'h2: b = s.exc ? s.code : s.start[15:8];
            3'h3: b = s.start[7:0];
            3'h4: b = s.qty[15:8];
            3'h5: b = s.qty[7:0];
            default: b = s.addr;
        endcase
        return b;
    endfunction

    // ******************************
    // request checks
    // ******************************
    assign acc = rx_valid && rx_ready;
    assign bcast = s_q.addr == `BCAST_ADDR;
    assign own = !bcast && s_q.addr == my_addr;
    assign gw = !bcast && !own;
    assign len_ok = !s_q.ovf && s_q.idx == (`HDR_LEN + {1'b0, s_q.bcnt});
    assign coil_bytes = ({1'b0, s_q.qty} + 17'h00007) >> 3;
    assign coil_struct = s_q.qty != 16'h0000 && len_ok
        && coil_bytes == {9'h000, s_q.bcnt};
    assign coil_range = ({1'b0, s_q.start} + {1'b0, s_q.qty})
        <= `COIL_RANGE;
    assign reg_struct = s_q.qty != 16'h0000 && s_q.qty <= `MAX_REGS
        && len_ok && {8'h00, s_q.bcnt} == {s_q.qty[14:0], 1'b0};
    assign reg_range = ({1'b0, s_q.start} + {1'b0, s_q.qty})
        <= `REG_RANGE;
    assign bcast_ok = configured && !prog_busy && !int_fault
        && ((s_q.func == `FC_COILS && coil_struct && coil_range)
        || (s_q.func == `FC_REGS && reg_struct && reg_range));

    always_comb
    begin
        chk = `EXC_NONE;
        if (gw)
        begin
            if (gw_path_fail)
                chk = `EXC_GW_PATH;
            else if (gw_no_resp)
                chk = `EXC_GW_TGT;
        end
        else if (prog_busy)
            chk = `EXC_BUSY;
        else if (!configured)
            chk = `EXC_FUNC;
        else if (int_fault)
            chk = `EXC_FAIL;
        else if (s_q.func == `FC_COILS)
        begin
            if (!coil_struct)
                chk = `EXC_VALUE;
            else if (!coil_range)
                chk = `EXC_ADDR;
        end
        else if (s_q.func == `FC_REGS)
        begin
            if (!reg_struct)
                chk = `EXC_VALUE;
            else if (!reg_range)
                chk = `EXC_ADDR;
        end
        else if (s_q.func == `FC_FILE_RD)
            chk = file_parity_err ? `EXC_PARITY : `EXC_FUNC;
        else if (s_q.func == `FC_PROG)
            chk = `EXC_ACK;
        else
            chk = `EXC_FUNC;
    end

    // ******************************
    // write ports
    // ******************************
    assign waddr16 = s_q.start + s_q.k;
    assign coil_byte = buf_mem[s_q.k[10:3]];
    assign coil_we = s_q.fsm == S_WRITE && s_q.func == `FC_COILS;
    assign coil_waddr = waddr16[`COIL_AW-1:0];
    assign coil_wdata = coil_byte[s_q.k[2:0]];
    assign reg_we = s_q.fsm == S_WRITE && s_q.func == `FC_REGS;
    assign reg_waddr = waddr16[`REG_AW-1:0];
    assign reg_wdata = {buf_mem[{s_q.k[6:0], 1'b0}],
                        buf_mem[{s_q.k[6:0], 1'b1}]};
    assign buf_waddr = 8'(s_q.idx - `HDR_LEN);

    coil_bank u_coils (
        .clock(clock),
        .we(coil_we),
        .waddr(coil_waddr),
        .wdata(coil_wdata),
        .coil_out(coil_out)
    );

    holding_bank u_regs (
        .clock(clock),
        .we(reg_we),
        .waddr(reg_waddr),
        .wdata(reg_wdata),
        .raddr(hr_rd_addr),
        .rdata(hr_rd_data)
    );

    always_ff @(posedge clock)
    begin
        if (s_q.fsm == S_RECV && acc && s_q.idx >= `HDR_LEN
            && s_q.idx < `IDX_MAX)
            buf_mem[buf_waddr] <= rx_data;
    end

    // ******************************
    // sequencer
    // ******************************
    always_comb
    begin
        s_d = s_q;
        s_d.prog = 1'b0;
        unique case (s_q.fsm)
            S_IDLE:
                if (acc)
                begin
                    s_d.addr = rx_data;
                    s_d.func = 8'h00;
                    s_d.start = 16'h0000;
                    s_d.qty = 16'h0000;
                    s_d.bcnt = 8'h00;
                    s_d.idx = `IX_FUNC;
                    s_d.ovf = 1'b0;
                    s_d.k = 16'h0000;
                    s_d.fault = 1'b0;
                    s_d.fsm = rx_last ? S_IDLE : S_RECV;
                end
            S_RECV:
                if (acc)
                begin
                    if (s_q.idx == `IX_FUNC)
                        s_d.func = rx_data;
                    if (s_q.idx == `IX_SH)
                        s_d.start[15:8] = rx_data;
                    if (s_q.idx == `IX_SL)
                        s_d.start[7:0] = rx_data;
                    if (s_q.idx == `IX_QH)
                        s_d.qty[15:8] = rx_data;
                    if (s_q.idx == `IX_QL)
                        s_d.qty[7:0] = rx_data;
                    if (s_q.idx == `IX_BC)
                        s_d.bcnt = rx_data;
                    if (s_q.idx == `IDX_MAX)
                        s_d.ovf = 1'b1;
                    else
                        s_d.idx = s_q.idx + 9'h001;
                    if (rx_last)
                        s_d.fsm = rx_err ? S_IDLE : S_CHECK;
                end
            S_CHECK:
            begin
                s_d.code = chk;
                s_d.exc = chk != `EXC_NONE;
                s_d.ridx = 3'h0;
                s_d.tx_data = s_q.addr;
                if (bcast)
                begin
                    s_d.exc = 1'b0;
                    s_d.fsm = bcast_ok ? S_WRITE : S_IDLE;
                end
                else if (chk != `EXC_NONE)
                begin
                    s_d.fsm = S_REPLY;
                    s_d.prog = own && chk == `EXC_ACK;
                end
                else
                    s_d.fsm = own ? S_WRITE : S_IDLE;
            end
            S_WRITE:
            begin
                if (int_fault)
                    s_d.fault = 1'b1;
                if (s_q.k == s_q.qty - 16'h0001)
                begin
                    s_d.exc = s_q.fault || int_fault;
                    s_d.code = `EXC_FAIL;
                    s_d.ridx = 3'h0;
                    s_d.tx_data = s_q.addr;
                    s_d.fsm = bcast ? S_IDLE : S_REPLY;
                end
                else
                    s_d.k = s_q.k + 16'h0001;
            end
            S_REPLY:
                if (tx_ready)
                begin
                    if (tx_last)
                        s_d.fsm = S_IDLE;
                    else
                    begin
                        s_d.ridx = s_q.ridx + 3'h1;
                        s_d.tx_data = reply_byte(s_q, s_q.ridx + 3'h1);
                    end
                end
            default:
                s_d.fsm = S_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            s_q <= '{fsm: S_IDLE, default: '0};
        else
            s_q <= s_d;
    end

    assign rx_ready = s_q.fsm == S_IDLE || s_q.fsm == S_RECV;
    assign tx_valid = s_q.fsm == S_REPLY;
    assign tx_last = tx_valid
        && s_q.ridx == (s_q.exc ? `EXC_LAST : `NORM_LAST);
    assign tx_data = s_q.tx_data;
    assign prog_start = s_q.prog;

    // ******************************
    // checks
    // ******************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_bad_frame;
        rx_valid && rx_ready && rx_last && rx_err;
    endsequence

    sequence s_check_own;
        s_q.fsm == S_CHECK && own;
    endsequence

    sequence s_own_ready;
        s_check_own ##0 configured && !prog_busy && !int_fault;
    endsequence

    a_bad_frame_drop:
    assert property (s_bad_frame |=> s_q.fsm == S_IDLE ##1 !tx_valid)
        else $error("bad frame not dropped");

    a_busy_code:
    assert property ((s_check_own ##0 prog_busy)
        |=> tx_valid && s_q.code == `EXC_BUSY)
        else $error("busy request not answered 06");

    a_unconfig_code:
    assert property ((s_check_own ##0 !prog_busy && !configured)
        |=> tx_valid && s_q.code == `EXC_FUNC)
        else $error("unconfigured request not answered 01");

    a_qty_limit:
    assert property ((s_own_ready ##0 s_q.func == `FC_REGS
        && s_q.qty > `MAX_REGS) |=> s_q.exc && s_q.code == `EXC_VALUE)
        else $error("register quantity over limit accepted");

    a_coil_range:
    assert property ((s_own_ready ##0 s_q.func == `FC_COILS
        && coil_struct && !coil_range) |=> s_q.code == `EXC_ADDR)
        else $error("coil range fault not answered 02");

    a_coil_bcnt:
    assert property ((s_own_ready ##0 s_q.func == `FC_COILS
        && !coil_struct) |=> s_q.exc && s_q.code == `EXC_VALUE)
        else $error("coil byte count fault not answered 03");

    a_file_parity:
    assert property ((s_own_ready ##0 s_q.func == `FC_FILE_RD
        && file_parity_err) |=> s_q.code == `EXC_PARITY)
        else $error("file parity fault not answered 08");

    a_gw_path:
    assert property ((s_q.fsm == S_CHECK && gw && gw_path_fail)
        |=> tx_valid && s_q.code == `EXC_GW_PATH)
        else $error("gateway path fault not answered 0a");

    a_gw_target:
    assert property ((s_q.fsm == S_CHECK && gw && !gw_path_fail
        && gw_no_resp) |=> tx_valid && s_q.code == `EXC_GW_TGT)
        else $error("gateway target fault not answered 0b");

    a_prog_ack:
    assert property (prog_start |-> tx_valid && s_q.code == `EXC_ACK
        && s_q.ridx == 3'h0)
        else $error("program start without 05 reply");

    a_write_fault:
    assert property ((s_q.fsm == S_WRITE && !bcast && int_fault)
        |=> s_q.fault || (tx_valid && s_q.code == `EXC_FAIL && s_q.exc))
        else $error("internal fault during write lost");

    a_exc_func_msb:
    assert property ((tx_valid && s_q.exc && s_q.ridx == 3'h1)
        |-> tx_data == (s_q.func | `EXC_FLAG))
        else $error("exception function byte lacks msb");

    // counts reply bytes taken, so stalls on the reply sink do not matter
    logic [2:0] sent_q;

    always_ff @(posedge clock)
    begin
        if (sys_rst || !tx_valid)
            sent_q <= 3'h0;
        else if (tx_ready)
            sent_q <= sent_q + 3'h1;
    end

    a_reply_len:
    assert property ((tx_valid && tx_ready && tx_last)
        |-> sent_q == (s_q.exc ? `EXC_LAST : `NORM_LAST))
        else $error("reply byte count wrong");

    a_bcast_quiet:
    assert property ((s_q.fsm == S_CHECK && bcast) |=> !tx_valid[*3])
        else $error("broadcast produced a reply");

    a_coil_write:
    assert property (coil_we
        |=> coil_out[$past(coil_waddr)] == $past(coil_wdata))
        else $error("coil not written from packed bit");

endmodule // modbus_write_server

// ===== master_model.sv
// remote master model: sends request frames and takes reply frames
// assumes: one clock shared with the handler; drives on falling edges
`timescale 1ns/1ps

module master_model (
    // clock
    input wire logic clock,
    // request stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_err,
    input wire logic rx_ready,
    // reply stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready
);
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        rx_err = 1'b0;
        tx_ready = 1'b0;
    end

    // ****************************************
    // request frame: header, count, high byte then low byte
    // ****************************************
    task automatic send(input logic [7:0] f[$], input logic err,
                        output logic hung);
        int w;
        hung = 1'b0;
        foreach (f[i])
        begin
            @(negedge clock);
            rx_valid = 1'b1;
            rx_data = f[i];
            rx_last = (i == f.size() - 1);
            rx_err = err && (i == f.size() - 1);
            w = 0;
            while (rx_ready !== 1'b1 && w < 300)
            begin
                @(negedge clock);
                w++;
            end
            hung = hung | (w >= 300);
            @(posedge clock);
        end
        @(negedge clock);
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_err = 1'b0;
        rx_data = ~rx_data;
    endtask

    // ****************************************
    // reply frame, optionally stalling before each byte
    // ****************************************
    task automatic recv(input int stall, input int lim,
                        output logic [7:0] r[$], output logic hung);
        int w;
        int s;
        logic done;
        r = {};
        w = 0;
        s = 0;
        done = 1'b0;
        while (!done && w < lim)
        begin
            @(negedge clock);
            w++;
            if (tx_valid === 1'b1 && s >= stall)
            begin
                tx_ready = 1'b1;
                r.push_back(tx_data);
                done = (tx_last === 1'b1);
                s = 0;
            end
            else
            begin
                tx_ready = 1'b0;
                s = s + ((tx_valid === 1'b1) ? 1 : 0);
            end
        end
        @(negedge clock);
        tx_ready = 1'b0;
        hung = !done;
    endtask
endmodule // master_model

// ===== tb.sv
// self-checking bench for the multiple-write request handler
// assumes: master_model drives requests and takes replies
`timescale 1ns/1ps
`include "modbus_srv_regs.svh"

module tb;
    typedef struct {
        logic [87:0] req;
        int n;
        logic [7:0] code;
        logic silent;
        logic [6:0] fl;
    } row_t;

    logic clock, sys_rst, configured, prog_busy, int_fault;
    logic file_parity_err, gw_path_fail, gw_no_resp, prog_start;
    logic rx_valid, rx_last, rx_err, rx_ready, tx_valid, tx_last, tx_ready;
    logic [7:0] my_addr, rx_data, tx_data;
    logic [`COIL_N-1:0] coil_out;
    logic [`REG_AW-1:0] hr_rd_addr;
    logic [15:0] hr_rd_data;
    int bad_count = 0;
    int tests_run = 0;
    int prog_cnt = 0;

    // ****************************************
    // rows: request, length, code, silent, {err,cfg,busy,fault,par,path,nr}
    // ****************************************
    row_t rows[20] = '{
    '{88'h110F0013000A02CD010000, 9, 8'h00, 1'b0, 7'h20},
    '{88'h11100007000204000A0102, 11, 8'h00, 1'b0, 7'h20},
    '{88'h110F00FE00020103000000, 8, 8'h00, 1'b0, 7'h20},
    '{88'h110F00FF00020103000000, 8, 8'h02, 1'b0, 7'h20},
    '{88'h1110007F00020400010002, 11, 8'h02, 1'b0, 7'h20},
    '{88'h110F0000000A01FF000000, 8, 8'h03, 1'b0, 7'h20},
    '{88'h1103000000010000000000, 6, 8'h01, 1'b0, 7'h20},
    '{88'h11100007000204000A0102, 11, 8'h01, 1'b0, 7'h00},
    '{88'h11100007000204000A0102, 11, 8'h04, 1'b0, 7'h28},
    '{88'h11100007000204000A0102, 11, 8'h06, 1'b0, 7'h30},
    '{88'h11100007000204000A0102, 11, 8'h00, 1'b0, 7'h20},
    '{88'h1128000000010000000000, 6, 8'h05, 1'b0, 7'h20},
    '{88'h1114060001000000000000, 6, 8'h08, 1'b0, 7'h24},
    '{88'h1114060001000000000000, 6, 8'h01, 1'b0, 7'h20},
    '{88'h22100007000204000A0102, 11, 8'h0A, 1'b0, 7'h22},
    '{88'h22100007000204000A0102, 11, 8'h0B, 1'b0, 7'h21},
    '{88'h000F003000030105000000, 8, 8'h00, 1'b1, 7'h20},
    '{88'h0003000000010000000000, 6, 8'h00, 1'b1, 7'h20},
    '{88'h00100009000102ABCD0000, 9, 8'h00, 1'b1, 7'h20},
    '{88'h11100007000102FFFF0000, 9, 8'h00, 1'b1, 7'h60}};

    modbus_write_server modbus_write_server_inst (
        .clock, .sys_rst, .my_addr, .configured, .prog_busy, .int_fault,
        .file_parity_err, .gw_path_fail, .gw_no_resp, .prog_start,
        .rx_valid, .rx_data, .rx_last, .rx_err, .rx_ready,
        .tx_valid, .tx_data, .tx_last, .tx_ready,
        .coil_out, .hr_rd_addr, .hr_rd_data
    );

    master_model master_model_inst (
        .clock, .rx_valid, .rx_data, .rx_last, .rx_err, .rx_ready,
        .tx_valid, .tx_data, .tx_last, .tx_ready
    );

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock)
        if (prog_start === 1'b1)
            prog_cnt <= prog_cnt + 1;

    // ****************************************
    // helpers
    // ****************************************
    task automatic print_verdict();
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic hang_out();
        bad_count++;
        $display("ERROR %0t wait bound used up", $time);
        print_verdict();
    endtask

    task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
        @(negedge clock);
        hr_rd_addr = a;
        @(negedge clock);
        chk({16'h0, hr_rd_data}, {16'h0, exp}, "holding register");
    endtask

    task automatic run(input logic [7:0] q[$], input logic [7:0] code,
                       input logic silent, input logic [6:0] fl, input int st);
        logic [7:0] r[$];
        logic [7:0] e[$];
        logic hung;
        int p0;
        @(negedge clock);
        {configured, prog_busy, int_fault, file_parity_err, gw_path_fail,
            gw_no_resp} = fl[5:0];
        p0 = prog_cnt;
        master_model_inst.send(q, fl[6], hung);
        if (hung)
            hang_out();
        master_model_inst.recv(st, silent ? 40 : 400, r, hung);
        if (hung && !silent)
            hang_out();
        if (silent)
            e = {};
        else if (code == `EXC_NONE)
            e = q[0:5];
        else
            e = {q[0], q[1] | `EXC_FLAG, code};
        chk(32'(r.size()), 32'(e.size()), "reply length");
        foreach (e[i])
            chk({24'h0, r[i]}, {24'h0, e[i]}, "reply byte");
        chk(32'(prog_cnt - p0), {31'h0, code == `EXC_ACK}, "pulse");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [7:0] q[$];
        logic [7:0] r[$];
        logic hung;
        sys_rst = 1'b1;
        my_addr = 8'h11;
        {configured, prog_busy, int_fault, file_parity_err} = 4'h8;
        {gw_path_fail, gw_no_resp} = 2'h0;
        hr_rd_addr = 7'h00;
        repeat (20) @(negedge clock);
        chk({20'h0, rx_ready, tx_valid, tx_last, prog_start, tx_data},
            32'h800, "reset outputs");
        sys_rst = 1'b0;
        foreach (rows[i])
        begin
            q = {};
            for (int j = 0; j < rows[i].n; j++)
                q.push_back(rows[i].req[87 - 8 * j -: 8]);
            run(q, rows[i].code, rows[i].silent, rows[i].fl, i % 3);
        end
        chk(32'(coil_out[8'h1C:8'h13]), 32'h1CD, "coil block");
        chk(32'(coil_out[8'hFF:8'hFE]), 32'h3, "coil top");
        chk(32'(coil_out[8'h32:8'h30]), 32'h5, "broadcast coils");
        rchk(7'h07, 16'h000A);
        rchk(7'h08, 16'h0102);
        rchk(7'h09, 16'hABCD);
        q = {8'h11, `FC_REGS, 8'h00, 8'h00, 8'h00, 8'h7D, 8'hFA};
        for (int j = 0; j < 250; j++)
            q.push_back(8'(j));
        run(q, `EXC_NONE, 1'b0, 7'h20, 0);
        rchk(7'h7C, 16'hF8F9);
        master_model_inst.send(q, 1'b0, hung);
        @(negedge clock);
        int_fault = 1'b1;
        @(negedge clock);
        int_fault = 1'b0;
        if (hung)
            hang_out();
        master_model_inst.recv(0, 400, r, hung);
        if (hung)
            hang_out();
        chk(32'(r.size()), 32'h3, "fault reply length");
        chk({24'h0, r[1]}, {24'h0, `FC_REGS | `EXC_FLAG}, "fault fc");
        chk({24'h0, r[2]}, {24'h0, `EXC_FAIL}, "fault code");
        q[5] = 8'h7E;
        q[6] = 8'hFC;
        q.push_back(8'h01);
        q.push_back(8'h02);
        run(q, `EXC_VALUE, 1'b0, 7'h20, 1);
        master_model_inst.send(q, 1'b0, hung);
        if (hung)
            hang_out();
        repeat (3) @(negedge clock);
        sys_rst = 1'b1;
        @(negedge clock);
        chk({20'h0, rx_ready, tx_valid, tx_last, prog_start, tx_data},
            32'h800, "mid-run reset");
        sys_rst = 1'b0;
        chk(32'(coil_out[8'h1C:8'h13]), 32'h1CD, "coils kept");
        q = {};
        for (int j = 0; j < rows[0].n; j++)
            q.push_back(rows[0].req[87 - 8 * j -: 8]);
        run(q, `EXC_NONE, 1'b0, 7'h20, 2);
        print_verdict();
    end
endmodule // tb
